// >>> bench/acr_rx_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acr_rx_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic double_speed_sel_i,
  input wire logic [11:0] baud_divisor_i,
  input wire logic [3:0] data_bits_i,
  input wire logic serial_rx_line_i,
  input wire logic frame_valid_o,
  input wire logic frame_ready_i,
  input wire logic [8:0] frame_data_o,
  input wire logic frame_error_flag_o,
  input wire logic busy_o,
  input wire logic overrun_o
);
  logic [15:0] busy_cnt;
  always_ff @(posedge clk_i) begin
    if (reset_i || !busy_o) busy_cnt <= 16'h0;
    else busy_cnt <= busy_cnt + 16'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_busy_entry: assert property ($rose(busy_o) |-> !$past(serial_rx_line_i, 3))
    else $error("busy rose without a low line");
  a_idle_quiet: assert property ((serial_rx_line_i && !busy_o) [*8] |=> !busy_o)
    else $error("busy rose on an idle line");
  a_start_norm: assert property ($fell(busy_o) && !double_speed_sel_i
    |-> busy_cnt >= 9 * (baud_divisor_i + 1)) else $error("start judged too early");
  a_start_dbl: assert property ($fell(busy_o) && double_speed_sel_i
    |-> busy_cnt >= 5 * (baud_divisor_i + 1)) else $error("double start too early");
  a_busy_max: assert property ($fell(busy_o)
    |-> busy_cnt <= 192 * (baud_divisor_i + 1)) else $error("frame ran too long");
  a_frame_hold: assert property (frame_valid_o && !frame_ready_i
    |=> frame_valid_o && $stable(frame_data_o) && $stable(frame_error_flag_o))
    else $error("frame changed before it was taken");
  a_upper_zero: assert property (frame_valid_o
    |-> (frame_data_o >> data_bits_i) == 9'h0) else $error("unused data bits set");
  a_tick_gap: assert property ($fell(busy_o) |=> !busy_o)
    else $error("busy rose between sample ticks");
  cover property ($rose(frame_valid_o) && frame_error_flag_o);
  cover property ($fell(busy_o) && busy_cnt < 16'd100);
  cover property (frame_valid_o && !frame_ready_i && double_speed_sel_i);
  cover property ($rose(overrun_o));
endmodule
bind acr_rx acr_rx_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
  .double_speed_sel_i(double_speed_sel_i), .baud_divisor_i(baud_divisor_i),
  .data_bits_i(data_bits_i), .serial_rx_line_i(serial_rx_line_i),
  .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i),
  .frame_data_o(frame_data_o), .frame_error_flag_o(frame_error_flag_o),
  .busy_o(busy_o), .overrun_o(overrun_o));
`default_nettype wire

// >>> bench/acr_rx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acr_rx_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ds = 1'b0;
  logic [11:0] div = 12'h003;
  logic [3:0] nb = 4'h8;
  logic ready = 1'b0;
  wire line;
  wire vld;
  wire fe;
  wire busy;
  wire ovr;
  wire [8:0] dat;
  int err_count = 0;
  int samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  acr_tx_model tx (.clk_i(clk_i), .line_o(line));
  acr_rx dut (.clk_i(clk_i), .reset_i(reset_i), .double_speed_sel_i(ds),
    .baud_divisor_i(div), .data_bits_i(nb), .serial_rx_line_i(line),
    .frame_valid_o(vld), .frame_ready_i(ready), .frame_data_o(dat),
    .frame_error_flag_o(fe), .busy_o(busy), .overrun_o(ovr));
  // ----
  // Checks
  // ----
  task chk(input logic [9:0] g, input logic [9:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait, so a lost frame fails instead of hanging.
  task get(input logic [9:0] e);
    int i;
    i = 0;
    while (vld !== 1'b1 && i < 2000) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    if (vld !== 1'b1) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, vld, 1'b1);
    end
    chk({fe, dat}, e);
    ready = 1'b1;
    @(posedge clk_i);
    #1;
    ready = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task test_done;
    $display("errors=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_norm;
    tx.send(9'h0a5, 8, 1'b1, 64);
    get(10'h0a5);
    tx.send(9'h05a, 8, 1'b1, 62);
    get(10'h05a);
  endtask
  task t_dbl;
    ds = 1'b1;
    tx.send(9'h03c, 8, 1'b1, 32);
    get(10'h03c);
    tx.send(9'h0c3, 8, 1'b1, 31);
    get(10'h0c3);
    ds = 1'b0;
  endtask
  task t_ferr;
    tx.send(9'h081, 8, 1'b0, 64);
    get(10'h281);
  endtask
  task t_noise;
    tx.hold(1'b0, 12);
    tx.hold(1'b1, 64);
    chk({8'h0, busy, vld}, 10'h0);
    ds = 1'b1;
    tx.hold(1'b0, 8);
    tx.hold(1'b1, 32);
    chk({8'h0, busy, vld}, 10'h0);
    ds = 1'b0;
    tx.send(9'h066, 8, 1'b1, 64);
    get(10'h066);
  endtask
  task t_width;
    nb = 4'h9;
    tx.send(9'h1a5, 9, 1'b1, 64);
    get(10'h1a5);
    nb = 4'h5;
    tx.send(9'h035, 5, 1'b1, 64);
    get(10'h015);
    nb = 4'h8;
  endtask
  // Frames back to back with one stop bit pile up while nobody reads.
  task t_b2b;
    for (int k = 0; k < 5; k++) tx.send(9'(8'h30 + k), 8, 1'b1, 64);
    chk({9'h0, ovr}, 10'h000);
    for (int k = 0; k < 5; k++) get(10'(8'h30 + k));
  endtask
  // Six frames fill the buffer, the seventh waits and the eighth overwrites it.
  task t_ovr;
    for (int k = 0; k < 8; k++) tx.send(9'(8'h40 + k), 8, 1'b1, 64);
    chk({9'h0, ovr}, 10'h001);
    for (int k = 0; k < 6; k++) get(10'(8'h40 + k));
    get(10'h047);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    @(posedge clk_i);
    #1;
    t_norm;
    t_dbl;
    t_ferr;
    t_noise;
    t_width;
    t_b2b;
    t_ovr;
    test_done;
  end
  initial begin
    #150000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire

// >>> bench/acr_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module acr_tx_model (
  // Clock and line.
  input wire logic clk_i,
  output var logic line_o
);
  // ----
  // Remote transmitter
  // ----
  // The line rests high between frames, as a real transmitter leaves it.
  initial line_o = 1'b1;
  task automatic hold(input logic v, input int n);
    line_o = v;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // The caller sets the bit period and must keep it inside tolerance.
  task automatic send(input logic [8:0] d, input int nb, input logic stop,
                      input int per);
    hold(1'b0, per);
    for (int i = 0; i < nb; i++) hold(d[i], per);
    hold(stop, per);
    // A broken stop bit is followed by one idle bit so the line rests high.
    if (!stop) hold(1'b1, per);
  endtask
endmodule
`default_nettype wire

// >>> logic/acr_fifo.v
`timescale 1ns/1ps
`default_nettype none
module acr_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset.
  input wire clk_i,
  input wire reset_i,
  // Write side.
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Read side.
  output wire out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] count_reg;
  reg out_valid_reg;
  wire do_wr;
  wire do_rd;
  wire [AW:0] stored;

  // ----------------------------------------
  // Storage with a registered read port.
  // ----------------------------------------
  // The output register is one extra slot; it does not count toward occupancy.
  assign stored = count_reg;
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready_i);
  assign out_valid_o = out_valid_reg;

  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_reg <= rd_reg + 1'b1;
        out_data_o <= mem_reg[rd_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_reg <= 1'b0;
      end
      count_reg <= stored + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule
`default_nettype wire

// >>> logic/acr_rx.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_rx_regs.vh"
module acr_rx (
  // Clock and reset.
  input wire clk_i,
  input wire reset_i,
  // Configuration.
  input wire double_speed_sel_i,
  input wire [`ACR_DIV_W-1:0] baud_divisor_i,
  input wire [3:0] data_bits_i,
  // Serial line.
  input wire serial_rx_line_i,
  // Received frames: data in [8:0], frame error in [9] of the buffered word; bit [10] is always zero.
  output reg frame_valid_o,
  input wire frame_ready_i,
  output reg [8:0] frame_data_o,
  output reg frame_error_flag_o,
  // Status.
  output reg busy_o,
  output reg overrun_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;

  reg [1:0] state_reg;
  reg line_meta_reg;
  reg line_reg;
  reg line_prev_reg;
  reg [`ACR_DIV_W-1:0] div_reg;
  reg tick_reg;
  reg [4:0] sample_reg;
  reg [1:0] vote_reg;
  reg [3:0] bit_reg;
  reg [9:0] shift_reg;
  reg push_reg;
  reg [`ACR_WORD_W-1:0] push_data_reg;
  wire [4:0] spb;
  wire [4:0] vote_first;
  wire [4:0] vote_last;
  wire [4:0] sample_next;
  wire majority;
  wire fifo_ready;
  wire fifo_valid;
  wire [`ACR_WORD_W-1:0] fifo_data;

  // ----------------------------------------
  // Line synchroniser and sample tick.
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      line_meta_reg <= 1'b1;
      line_reg <= 1'b1;
      div_reg <= {`ACR_DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end else begin
      line_meta_reg <= serial_rx_line_i;
      line_reg <= line_meta_reg;
      // The tick rate is the sample rate; the divisor sets it alone.
      if (div_reg == {`ACR_DIV_W{1'b0}}) begin
        div_reg <= baud_divisor_i;
        tick_reg <= 1'b1;
      end else begin
        div_reg <= div_reg - 1'b1;
        tick_reg <= 1'b0;
      end
    end
  end

  // Fewer samples per bit at the same tick doubles the bit rate.
  assign spb = double_speed_sel_i ? `ACR_SPB_DOUBLE : `ACR_SPB_NORMAL;
  assign vote_first = double_speed_sel_i ? `ACR_VOTE_DOUBLE : `ACR_VOTE_NORMAL;
  assign vote_last = vote_first + 5'h02;
  // At a tick the synchronised line shows the sample after the one counted.
  assign sample_next = sample_reg + 5'h01;
  // Two of three decide the level. The last sample comes straight off the line, so the
  // decision falls on the last voting sample and a new edge is seen one later.
  assign majority = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & line_reg) |
                    (vote_reg[0] & line_reg);

  // ----------------------------------------
  // Start detection and data recovery.
  // ----------------------------------------
  // Tolerance of the far transmitter is its own concern; this receiver
  // only centres its votes on each realigned start.
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      line_prev_reg <= 1'b1;
      sample_reg <= 5'h00;
      vote_reg <= 2'h0;
      bit_reg <= 4'h0;
      shift_reg <= 10'h000;
      push_reg <= 1'b0;
      push_data_reg <= {`ACR_WORD_W{1'b0}};
      busy_o <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      if (push_reg && fifo_ready) begin
        push_reg <= 1'b0;
      end
      if (tick_reg) begin
        line_prev_reg <= line_reg;
        case (state_reg)
          ST_IDLE: begin
            // Falling edge found: this low sample is number 1.
            if (line_prev_reg && !line_reg) begin
              state_reg <= ST_START;
              sample_reg <= 5'h01;
              // Every frame restarts its bit count from its own start bit.
              bit_reg <= 4'h0;
              busy_o <= 1'b1;
            end
          end
          ST_START: begin
            sample_reg <= sample_next;
            // Samples 8..10 or 4..6 of the start bit are voted.
            if (sample_next == vote_first || sample_next == vote_first + 5'h01) begin
              vote_reg <= {vote_reg[0], line_reg};
            end
            if (sample_next == vote_last) begin
              if (majority) begin
                state_reg <= ST_IDLE;
                busy_o <= 1'b0;
              end else begin
                // Bit timing now counts from the start bit.
                state_reg <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            // State counter wraps every bit.
            sample_reg <= (sample_reg == spb) ? 5'h01 : sample_next;
            if (sample_next == vote_first || sample_next == vote_first + 5'h01) begin
              vote_reg <= {vote_reg[0], line_reg};
            end
            if (sample_next == vote_last) begin
              bit_reg <= bit_reg + 1'b1;
              if (bit_reg == data_bits_i) begin
                // First stop bit decided; further stops are never sampled.
                // A new edge is looked for right away.
                state_reg <= ST_IDLE;
                busy_o <= 1'b0;
                overrun_o <= push_reg && !fifo_ready;
                push_reg <= 1'b1;
                push_data_reg <= {1'b0, !majority, shift_reg[8:0]};
                shift_reg <= 10'h000;
              end else begin
                shift_reg[bit_reg] <= majority;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Frame buffer and output stage.
  // ----------------------------------------
  // The error bit travels in the same word as its frame.
  acr_fifo #(
    .WIDTH(`ACR_WORD_W),
    .DEPTH(`ACR_FIFO_DEPTH),
    .AW(`ACR_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data_reg),
    .out_valid_o(fifo_valid),
    .out_ready_i(!frame_valid_o || frame_ready_i),
    .out_data_o(fifo_data)
  );

  always @(posedge clk_i) begin
    if (reset_i) begin
      frame_valid_o <= 1'b0;
      frame_data_o <= 9'h000;
      frame_error_flag_o <= 1'b0;
    end else if (!frame_valid_o || frame_ready_i) begin
      frame_valid_o <= fifo_valid;
      frame_data_o <= fifo_data[8:0];
      frame_error_flag_o <= fifo_data[9];
    end
  end
endmodule
`default_nettype wire

// >>> logic/acr_rx_regs.vh
// Overview of operation
// - Sample the line sixteen times per bit, eight in double speed.
// - Idle: a falling edge starts detection; first low sample is number 1.
// - Normal mode validates the start bit on samples 8, 9 and 10.
// - Double speed validates the start bit on samples 4, 5 and 6.
// - Two or more high validation samples reject the start as noise.
// - An accepted start bit realigns bit timing, again for every frame.
// - A per-bit counter of 16 or 8 states numbers each sample.
// - Each bit is the majority of its three centre samples.
// - Voting starts at state 8 (normal) or 4 (double speed).
// - Recover data and parity up to the first stop bit; ignore later stops.
// - A stop bit voted zero sets the frame error flag for that frame.
// - A new start may follow the last stop vote, at once in either mode.
// - Receiver and transmitter each take half the error, e.g. 2.0 percent.
// - Double speed halves the divider ratio from sixteen to eight.
// - The frame error is stored in the buffer with its frame.
`ifndef ACR_RX_REGS_VH
`define ACR_RX_REGS_VH
`define ACR_SPB_NORMAL 5'h10
`define ACR_SPB_DOUBLE 5'h08
`define ACR_VOTE_NORMAL 5'h08
`define ACR_VOTE_DOUBLE 5'h04
`define ACR_DIV_W 12
`define ACR_FIFO_DEPTH 4
`define ACR_FIFO_AW 2
`define ACR_WORD_W 11
`endif
